// ===== inc/ext_bus_pkg.sv
// Constants and types shared by the external bus chip select and wait logic.
package ext_bus_pkg;
   localparam int ADDR_W = 24;
   localparam int WB_ADR_W = 16;
   localparam int WB_DAT_W = 32;

   // Register byte addresses on the Wishbone bus.
   localparam logic [15:0] CFG_OFFSET  = 16'hff00;
   localparam logic [15:0] WAIT_OFFSET = 16'hff04;

   // Field positions inside the configuration register.
   localparam int CE_EN_LSB     = 0;
   localparam int SIZE_SEL_LSB  = 4;
   localparam int MODE_SEL_LSB  = 6;
   // Field position inside the wait register.
   localparam int WAIT_CODE_LSB = 4;

   // Reset values.
   localparam logic [1:0] MODE_SEL_RESET  = 2'h0;
   localparam logic [1:0] SIZE_SEL_RESET  = 2'h3;
   localparam logic [2:0] CE_EN_RESET     = 3'h7;
   localparam logic [1:0] WAIT_CODE_RESET = 2'h0;

   // Wait states per code, and states per clock period.
   localparam logic [3:0] WAIT_STATES_3 = 4'hc;
   localparam logic [3:0] WAIT_STATES_2 = 4'h8;
   localparam logic [3:0] WAIT_STATES_1 = 4'h4;
   localparam logic [3:0] WAIT_STATES_0 = 4'h0;
   localparam logic [3:0] STATES_PER_CLOCK = 4'h2;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'h0,
      MODE_64K    = 2'h1,
      MODE_4M_MIN = 2'h2,
      MODE_4M_MAX = 2'h3
   } bus_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_T1   = 3'h1,
      ST_T2   = 3'h3,
      ST_T3   = 3'h2,
      ST_TW   = 3'h6,
      ST_T4   = 3'h7
   } bus_state_t;
endpackage

// ===== src/addr_range_hit.sv
// One address window comparator used by the chip select decoder.
`timescale 1ns/1ps
`default_nettype none
module addr_range_hit #(
   parameter int AW = 24
) (
   input  wire logic [AW-1:0] addr,
   input  wire logic [AW-1:0] lo,
   input  wire logic [AW-1:0] hi,
   input  wire logic          valid,
   output logic               hit
);
   assign hit = valid && (addr >= lo) && (addr <= hi);
endmodule
`default_nettype wire

// ===== src/ext_bus_chip_select_wait.sv
// External bus chip select decoder and wait state inserter, Wishbone slave.
//
// Function
// - Decoder drives three active-low chip selects.
// - Pins shared with port; enables reset one.
// - Enable zero turns pin into port output.
// - Single chip mode forces all pins port.
// - Select only inside its external area.
// - Standby drives all enabled chip selects high.
// - 64K mode uses size code ranges.
// - 64K with ROM: fixed table per code.
// - 64K without ROM: ranges start at zero.
// - 4M modes use fixed quarter ranges.
// - 4M without ROM: select 0 two ranges.
// - Wait codes give 12, 8, 4, 0 states.
// - Wait states sit between T3 and T4.
// - Each wait state is half a cycle.
// - No waits internal or on low speed clock.
// - Single chip mode ignores wait setting.
// - Without ROM, code 00 means strapped expanded mode.
// - Bus mode field codes, reset 00.
// - Size field resets 11, 64K only.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_chip_select_wait #(
   parameter ext_bus_pkg::bus_mode_t MPU_DEFAULT_MODE = ext_bus_pkg::MODE_4M_MAX
) (
   input  wire logic                             clock,
   input  wire logic                             rst,
   input  wire logic                             wb_cyc,
   input  wire logic                             wb_stb,
   input  wire logic                             wb_we,
   input  wire logic [ext_bus_pkg::WB_ADR_W-1:0] wb_adr,
   input  wire logic [3:0]                       wb_sel,
   input  wire logic [ext_bus_pkg::WB_DAT_W-1:0] wb_dat_w,
   output logic      [ext_bus_pkg::WB_DAT_W-1:0] wb_dat_r,
   output logic                                  wb_ack,
   input  wire logic                             no_internal_rom,
   input  wire logic                             cpu_start,
   input  wire logic [ext_bus_pkg::ADDR_W-1:0]   cpu_addr,
   input  wire logic                             cpu_internal,
   input  wire logic                             cpu_standby,
   input  wire logic                             cpu_low_speed,
   input  wire logic [2:0]                       port_data,
   output logic      [2:0]                       cs_pin,
   output logic      [2:0]                       ce_active,
   output logic                                  cycle_done,
   output logic                                  wait_active,
   output logic      [1:0]                       bus_mode
);
   import ext_bus_pkg::*;

   generate
      if (MPU_DEFAULT_MODE == MODE_SINGLE) begin : g_bad_mode
         $error("strapped default mode must be an expanded mode");
      end
   endgenerate

   typedef struct packed {
      logic [1:0] mode_sel;
      logic [1:0] size_sel;
      logic [2:0] ce_en;
      logic [1:0] wait_code;
      logic       mpu;
      bus_state_t st;
      logic [2:0] wcnt;
      logic       internal;
      logic [2:0] hit;
      logic [2:0] pin;
      logic       ack;
      logic [7:0] rdat;
   } state_t;

   state_t q;
   state_t d;

   bus_mode_t             eff_mode;
   logic [2:0]            ce_eff;
   logic [ADDR_W-1:0]     dec_addr;
   logic [ADDR_W-1:0]     lo [6];
   logic [ADDR_W-1:0]     hi [6];
   logic [5:0]            vl;
   logic [5:0]            slot_hit;
   logic [2:0]            hit_now;
   logic [3:0]            wait_states;
   logic [2:0]            wait_cycles;
   logic                  wb_req;
   logic                  cfg_sel;
   logic                  wait_sel;

   // Without internal ROM, code 00 falls back to the strapped mode.
   always_comb begin
      if (q.mode_sel == 2'h0 && q.mpu) begin
         eff_mode = MPU_DEFAULT_MODE;
      end else begin
         eff_mode = bus_mode_t'(q.mode_sel);
      end
   end

   // Single chip mode overrides the stored enables without touching them.
   assign ce_eff = (eff_mode == MODE_SINGLE) ? 3'h0 : q.ce_en;

   // The 64K mode only sees the low 16 address bits.
   assign dec_addr = (eff_mode == MODE_64K) ?
                     {8'h00, cpu_addr[15:0]} : cpu_addr;

   // Each select owns two windows: slots 2i and 2i+1.
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         lo[i] = 24'h000000;
         hi[i] = 24'h000000;
      end
      vl = 6'h00;
      unique case (eff_mode)
         MODE_64K: begin
            if (q.mpu) begin
               unique case (q.size_sel)
                  2'h3: begin
                     lo[0] = 24'h000000;
                     hi[0] = 24'h00efff;
                     vl = 6'h01;
                  end
                  2'h2: begin
                     lo[0] = 24'h000000;
                     hi[0] = 24'h007fff;
                     lo[2] = 24'h008000;
                     hi[2] = 24'h00efff;
                     vl = 6'h05;
                  end
                  2'h1: begin
                     lo[0] = 24'h000000;
                     hi[0] = 24'h003fff;
                     lo[2] = 24'h004000;
                     hi[2] = 24'h007fff;
                     lo[4] = 24'h008000;
                     hi[4] = 24'h00bfff;
                     vl = 6'h15;
                  end
                  2'h0: begin
                     lo[0] = 24'h000000;
                     hi[0] = 24'h001fff;
                     lo[2] = 24'h002000;
                     hi[2] = 24'h003fff;
                     lo[4] = 24'h004000;
                     hi[4] = 24'h005fff;
                     vl = 6'h15;
                  end
               endcase
            end else begin
               unique case (q.size_sel)
                  2'h3: begin
                     // Invalid with internal ROM: nothing is selected.
                     vl = 6'h00;
                  end
                  2'h2: begin
                     lo[0] = 24'h008000;
                     hi[0] = 24'h00efff;
                     vl = 6'h01;
                  end
                  2'h1: begin
                     lo[0] = 24'h007000;
                     hi[0] = 24'h00afff;
                     lo[2] = 24'h00b000;
                     hi[2] = 24'h00efff;
                     vl = 6'h05;
                  end
                  2'h0: begin
                     lo[0] = 24'h008000;
                     hi[0] = 24'h009fff;
                     lo[2] = 24'h00a000;
                     hi[2] = 24'h00bfff;
                     lo[4] = 24'h00c000;
                     hi[4] = 24'h00dfff;
                     vl = 6'h15;
                  end
               endcase
            end
         end
         MODE_4M_MIN, MODE_4M_MAX: begin
            lo[2] = 24'h400000;
            hi[2] = 24'h7fffff;
            lo[4] = 24'h800000;
            hi[4] = 24'hbfffff;
            if (q.mpu) begin
               lo[0] = 24'h000000;
               hi[0] = 24'h00efff;
               lo[1] = 24'h010000;
               hi[1] = 24'h3fffff;
               vl = 6'h17;
            end else begin
               lo[0] = 24'hc00000;
               hi[0] = 24'hffffff;
               vl = 6'h15;
            end
         end
         MODE_SINGLE: begin
            vl = 6'h00;
         end
      endcase
   end

   for (genvar g = 0; g < 6; g++) begin : g_slot
      addr_range_hit #(
         .AW    (ADDR_W)
      ) u_hit (
         .addr  (dec_addr),
         .lo    (lo[g]),
         .hi    (hi[g]),
         .valid (vl[g]),
         .hit   (slot_hit[g])
      );
   end

   // Internal accesses never reach an external select.
   for (genvar c = 0; c < 3; c++) begin : g_cs
      assign hit_now[c] = !cpu_internal &&
                          (slot_hit[2*c] || slot_hit[2*c+1]);
   end

   // One wait state lasts half a clock, so the states of a code take
   // half as many clocks, while each T state takes one whole clock.
   always_comb begin
      unique case (q.wait_code)
         2'h3: wait_states = WAIT_STATES_3;
         2'h2: wait_states = WAIT_STATES_2;
         2'h1: wait_states = WAIT_STATES_1;
         2'h0: wait_states = WAIT_STATES_0;
      endcase
      if (q.internal || cpu_low_speed ||
          eff_mode == MODE_SINGLE) begin
         wait_states = WAIT_STATES_0;
      end
   end
   assign wait_cycles = 3'(wait_states / STATES_PER_CLOCK);

   assign wb_req   = wb_cyc && wb_stb && !q.ack;
   assign cfg_sel  = wb_adr[WB_ADR_W-1:2] == CFG_OFFSET[15:2];
   assign wait_sel = wb_adr[WB_ADR_W-1:2] == WAIT_OFFSET[15:2];

   always_comb begin
      d = q;
      d.ack = wb_req;
      if (wb_req) begin
         d.rdat = 8'h00;
         if (cfg_sel) begin
            d.rdat = {q.mode_sel, q.size_sel, 1'b0, q.ce_en};
         end else if (wait_sel) begin
            d.rdat = {2'h0, q.wait_code, 4'h0};
         end
         if (wb_we && wb_sel[0] && cfg_sel) begin
            d.mode_sel = wb_dat_w[MODE_SEL_LSB+:2];
            d.size_sel = wb_dat_w[SIZE_SEL_LSB+:2];
            d.ce_en    = wb_dat_w[CE_EN_LSB+:3];
         end
         if (wb_we && wb_sel[0] && wait_sel) begin
            d.wait_code = wb_dat_w[WAIT_CODE_LSB+:2];
         end
      end

      unique case (q.st)
         ST_IDLE: begin
            d.hit = 3'h0;
            if (cpu_start) begin
               d.st       = ST_T1;
               d.internal = cpu_internal;
               d.hit      = hit_now;
            end
         end
         ST_T1: d.st = ST_T2;
         ST_T2: d.st = ST_T3;
         ST_T3: begin
            d.wcnt = wait_cycles;
            d.st = (wait_cycles == 3'h0) ? ST_T4 : ST_TW;
         end
         ST_TW: begin
            d.wcnt = q.wcnt - 3'h1;
            if (q.wcnt == 3'h1) begin
               d.st = ST_T4;
            end
         end
         ST_T4: d.st = ST_IDLE;
      endcase

      // The pin follows the next state, so it is low from T1 through T4.
      for (int i = 0; i < 3; i++) begin
         if (!ce_eff[i]) begin
            d.pin[i] = port_data[i];
         end else if (cpu_standby) begin
            d.pin[i] = 1'b1;
         end else begin
            d.pin[i] = !(d.st != ST_IDLE && d.hit[i]);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         q           <= '0;
         q.mode_sel  <= MODE_SEL_RESET;
         q.size_sel  <= SIZE_SEL_RESET;
         q.ce_en     <= CE_EN_RESET;
         q.wait_code <= WAIT_CODE_RESET;
         q.st        <= ST_IDLE;
         q.pin       <= 3'h7;
         // The strap is sampled by a clock edge while reset is held.
         q.mpu       <= no_internal_rom;
      end else begin
         q <= d;
      end
   end

   assign wb_dat_r    = {24'h000000, q.rdat};
   assign wb_ack      = q.ack;
   assign cs_pin      = q.pin;
   assign ce_active   = ce_eff;
   assign cycle_done  = q.st == ST_T4;
   assign wait_active = q.st == ST_TW;
   assign bus_mode    = eff_mode;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   reset_values_a: assert property (
      $past(rst) |-> q.ce_en == 3'h7 && q.size_sel == 2'h3 &&
                     q.mode_sel == 2'h0 && q.wait_code == 2'h0)
      else $error("register reset values wrong");
   port_mode_a: assert property (
      !ce_eff[0] |=> cs_pin[0] == $past(port_data[0]))
      else $error("disabled select does not follow port data");
   single_chip_a: assert property (
      eff_mode == MODE_SINGLE |=> cs_pin == $past(port_data))
      else $error("single chip mode does not force port output");
   internal_none_a: assert property (
      (q.st != ST_IDLE && q.internal) |-> q.hit == 3'h0)
      else $error("internal access hit a select");

   standby_high_a: assert property (
      cpu_standby |=> (cs_pin & $past(ce_eff)) == $past(ce_eff))
      else $error("select low during standby");

   wait_twelve_a: assert property (
      (q.st == ST_T3 && wait_states == 4'hc)
      |=> (q.st == ST_TW) [*6] ##1 q.st == ST_T4)
      else $error("twelve wait states not six clocks");

   wait_place_a: assert property (
      q.st == ST_TW |-> $past(q.st) == ST_T3 || $past(q.st) == ST_TW)
      else $error("wait state outside T3 to T4");

   no_wait_int_a: assert property (
      (q.st == ST_T3 && (q.internal || cpu_low_speed)) |=> q.st == ST_T4)
      else $error("wait inserted for internal or low speed");

   strap_mode_a: assert property (
      q.mpu |-> eff_mode != MODE_SINGLE)
      else $error("single chip mode without internal ROM");

   cs_held_a: assert property (
      (q.st == ST_T1 && q.hit[0] && ce_eff[0] && !cpu_standby)
      |-> !cs_pin[0] ##1 (!cs_pin[0] || cpu_standby || !$past(ce_eff[0])))
      else $error("select released inside bus cycle");

   wb_answer_a: assert property (
      (wb_cyc && wb_stb && !wb_ack) |=> wb_ack ##1 !wb_ack)
      else $error("wishbone ack not one cycle after request");
endmodule
`default_nettype wire

// ===== test/ext_mem_model.sv
// Model of the external memory chips that watch the chip select pins.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
   input  wire logic            clock,
   input  wire logic [2:0]      cs_pin,
   output logic      [2:0][7:0] run_len
);
   logic [2:0][7:0] cnt = '0;

   // Select 0 carries the program memory of a system without ROM.
   // Each chip reports how many clocks its select stayed low.
   always_ff @(posedge clock) begin
      for (int s = 0; s < 3; s++) begin
         if (cs_pin[s] === 1'b0) begin
            cnt[s] <= cnt[s] + 8'h01;
         end else begin
            if (cnt[s] != 8'h00) begin
               run_len[s] <= cnt[s];
            end
            cnt[s] <= 8'h00;
         end
      end
   end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the chip select decoder and wait inserter.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ext_bus_pkg::*;
   localparam bus_mode_t DEF_MODE = MODE_64K;
   logic clock, rst, wb_cyc, wb_stb, wb_we, wb_ack, no_internal_rom;
   logic cpu_start, cpu_internal, cpu_standby, cpu_low_speed;
   logic cycle_done, wait_active;
   logic [15:0] wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r, rdat;
   logic [23:0] cpu_addr;
   logic [2:0]  port_data, cs_pin, ce_active, m_ce;
   logic [1:0]  bus_mode, m_mode, m_size, m_wait;
   logic [2:0][7:0] run_len;
   bit mpu;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [15:0] lo_list [8] = '{16'h0100, 16'h2100, 16'h4100, 16'h9000,
                                16'ha100, 16'hd000, 16'hf800, 16'h8000};
   logic [23:0] hi_list [8] = '{24'h00efff, 24'h010000, 24'h3fffff,
      24'h400000, 24'h7fffff, 24'h800000, 24'hc00000, 24'h00f000};

   ext_bus_chip_select_wait #(.MPU_DEFAULT_MODE(DEF_MODE))
   ext_bus_chip_select_wait_i (.clock(clock), .rst(rst), .wb_cyc(wb_cyc),
      .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
      .no_internal_rom(no_internal_rom), .cpu_start(cpu_start),
      .cpu_addr(cpu_addr), .cpu_internal(cpu_internal),
      .cpu_standby(cpu_standby), .cpu_low_speed(cpu_low_speed),
      .port_data(port_data), .cs_pin(cs_pin), .ce_active(ce_active),
      .cycle_done(cycle_done), .wait_active(wait_active),
      .bus_mode(bus_mode));
   ext_mem_model ext_mem_model_i (.clock(clock), .cs_pin(cs_pin),
      .run_len(run_len));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic int eff_mode();
      return (m_mode == 2'h0 && mpu) ? int'(DEF_MODE) : int'(m_mode);
   endfunction

   function automatic logic [2:0] exp_sel(input int mode, input int c,
                                          input int a);
      int b;
      logic [2:0] r;
      b = a % 65536;
      r = 3'h0;
      if (mode == 1 && mpu) begin
         if (c == 3) r[0] = b <= 24'hefff;
         else if (c == 2) r = {1'b0, b >= 24'h8000 && b <= 24'hefff,
                               b < 24'h8000};
         else for (int s = 0; s < 3; s++)
            r[s] = b / (c == 1 ? 24'h4000 : 24'h2000) == s;
      end else if (mode == 1) begin
         if (c == 2) r[0] = b >= 24'h8000 && b <= 24'hefff;
         // Probe addresses stay clear of the 16K window edges.
         if (c == 1) r = {1'b0, b >= 24'hc000 && b <= 24'hefff,
                          b >= 24'h8000 && b <= 24'hafff};
         if (c == 0) for (int s = 0; s < 3; s++) r[s] = b / 24'h2000 == s + 4;
      end else if (mode >= 2) begin
         r[1] = a >= 24'h400000 && a < 24'h800000;
         r[2] = a >= 24'h800000 && a < 24'hc00000;
         r[0] = mpu ? (a <= 24'hefff || (a >= 24'h10000 && a < 24'h400000))
                    : a >= 24'hc00000;
      end
      return r;
   endfunction

   task automatic xfer(input bit we, input logic [15:0] adr,
                       input logic [31:0] dat, input logic [3:0] sel);
      int n;
      @(posedge clock);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat_w <= dat;
      wb_sel <= sel;
      // Ack is read right after the edge, so it is the value that edge saw.
      for (n = 0; n < 20; n++) begin
         @(posedge clock);
         if (wb_ack === 1'b1) break;
      end
      if (n == 20) begin
         n_mismatch++;
         print_verdict();
      end
      rdat = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (we && sel[0] && adr == CFG_OFFSET) begin
         {m_mode, m_size} = dat[7:4];
         m_ce = dat[2:0];
      end
      if (we && sel[0] && adr == WAIT_OFFSET) m_wait = dat[5:4];
   endtask

   task automatic cpu_cycle(input logic [23:0] a, input bit internal,
                            input bit ls, input bit sb);
      logic [2:0] en, act, pin;
      int w;
      en = (eff_mode() == 0) ? 3'h0 : m_ce;
      act = (internal ? 3'h0 : exp_sel(eff_mode(), m_size, a)) & en;
      act = sb ? 3'h0 : act;
      w = (internal || ls || eff_mode() == 0) ? 0 : 2 * m_wait;
      @(posedge clock);
      cpu_start <= 1'b1;
      cpu_addr <= a;
      cpu_internal <= internal;
      cpu_low_speed <= ls;
      cpu_standby <= sb;
      @(posedge clock);
      cpu_start <= 1'b0;
      for (int k = 1; k <= 5 + w; k++) begin
         @(negedge clock);
         pin = (en & ~(k <= 4 + w ? act : 3'h0)) | (~en & port_data);
         chk("cs_pin", pin, cs_pin);
         chk("cycle_done", k == 4 + w, cycle_done);
         chk("wait_active", k >= 4 && k < 4 + w, wait_active);
      end
      @(negedge clock);
      for (int s = 0; s < 3; s++)
         if (act[s]) chk("run_len", 4 + w, run_len[s]);
   endtask

   task automatic run_set();
      for (int m = 0; m < 4; m++) for (int c = 0; c < 4; c++) begin
         @(posedge clock);
         port_data <= 3'($urandom);
         xfer(1'b1, CFG_OFFSET, {24'h0, m[1:0], c[1:0], 1'b0,
              c[0] ? 3'h7 : 3'($urandom)}, 4'h1);
         // Stepping the wait code with both loops meets every code in
         // every bus mode, so the twelve state case is surely reached.
         xfer(1'b1, WAIT_OFFSET, {26'h0, 2'(c + m), 4'h0}, 4'hf);
         chk("bus_mode", eff_mode(), bus_mode);
         chk("ce_active", eff_mode() ? m_ce : 3'h0, ce_active);
         for (int j = 0; j < 8; j++) begin
            cpu_cycle(m == 1 ? {8'($urandom), lo_list[j]} : hi_list[j],
                      j == 0, 1'b0, 1'b0);
         end
      end
   endtask

   task automatic do_reset(input bit p);
      @(posedge clock);
      rst <= 1'b1;
      no_internal_rom <= p;
      repeat (8) @(posedge clock);
      @(negedge clock);
      chk("cs_pin", 3'h7, cs_pin);
      @(posedge clock);
      rst <= 1'b0;
      mpu = p;
      {m_mode, m_size, m_ce, m_wait} = {MODE_SEL_RESET, SIZE_SEL_RESET,
                                        CE_EN_RESET, WAIT_CODE_RESET};
      @(negedge clock);
   endtask

   initial begin
      {rst, wb_cyc, wb_stb, wb_we, cpu_start, cpu_internal} = 6'h21;
      {cpu_standby, cpu_low_speed, no_internal_rom} = 3'h0;
      {wb_adr, wb_sel, wb_dat_w, cpu_addr} = '0;
      port_data = 3'h7;
      void'($urandom(78054));
      for (int p = 0; p < 2; p++) begin
         do_reset(p);
         chk("bus_mode", p ? DEF_MODE : 0, bus_mode);
         chk("ce_active", p ? 3'h7 : 3'h0, ce_active);
         xfer(1'b0, CFG_OFFSET, 32'h0, 4'hf);
         chk("config", 32'h37, rdat);
         xfer(1'b0, WAIT_OFFSET, 32'h0, 4'hf);
         chk("wait", 32'h0, rdat);
         xfer(1'b1, 16'hff08, 32'hff, 4'hf);
         xfer(1'b0, 16'hff08, 32'h0, 4'hf);
         chk("unmapped", 32'h0, rdat);
         xfer(1'b1, CFG_OFFSET, 32'h0, 4'he);
         xfer(1'b0, CFG_OFFSET, 32'h0, 4'hf);
         chk("config", 32'h37, rdat);
         if (p) cpu_cycle(24'h0100, 1'b0, 1'b0, 1'b0);
         run_set();
         xfer(1'b1, CFG_OFFSET, 32'h47, 4'h1);
         xfer(1'b1, WAIT_OFFSET, 32'h30, 4'h1);
         xfer(1'b0, CFG_OFFSET, 32'h0, 4'hf);
         chk("config", 32'h47, rdat);
         cpu_cycle(p ? 24'h0100 : 24'h9000, 1'b0, 1'b1, 1'b0);
         cpu_cycle(p ? 24'h0100 : 24'h9000, 1'b0, 1'b0, 1'b1);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
